// ---- design/rxpm_top.sv ----
// Function
// - Controller mode 0 sends symbols to the packet path, serial mode to serial port.
// - Receive walks preamble qualification, delimiter search, then data symbols.
// - Serial mode emits four clock pulses and four data bits per symbol.
// - Serial mode stays in receive after every frame until a host command.
// - Delimiter register resets to the standard value; programmed value is used.
// - In packet mode, on delimiter the buffer is overwritten from the length byte onward.
// - FCS bypass stores FCS and signals frame received regardless of check.
// - Automatic FCS checks x16+x12+x5+1 and signals frame only on match.
// - Automatic FCS replaces the two FCS bytes by RSSI and quality value.
// - Post mode 0 returns to standby on frame received.
// - Each frame is written starting at the base pointer register.
// - After receive command no frame is accepted before the turn-on delay.
// - Post mode 1 stays receiving and re-arms one turn-on delay later.
// - Post mode 2 disables frame reception; buffer contents are preserved.
// - Turn-on delay is base field in 1 us plus extension in 4 us.
// - Quality value sits in the second FCS byte position.
// - Delimiter detection raises its own interrupt event.
`timescale 1ns/1ps
module rxpm_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [13:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  input  wire logic        sym_valid,
  input  wire logic [3:0]  sym_data,
  input  wire logic [7:0]  rssi_value,
  input  wire logic [7:0]  sqi_value,
  output logic             symbol_clock_out,
  output logic             symbol_data_out,
  output logic             phy_standby_state,
  output logic             rx_enabled,
  output logic             irq
);

  // CRC step over one byte, reflected form so bits go in LSB first
  function automatic logic [15:0] rxpm_crc_byte(input logic [15:0] c_in,
                                                input logic [7:0]  d);
    logic [15:0] c;
    logic        fb;
    c = c_in;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      c  = c >> 1;
      if (fb) begin
        c = c ^ rxpm_pkg::CRC_POLY_REFL;
      end
    end
    return c;
  endfunction

  logic [7:0]  buffer_config;
  logic [7:0]  radio_ctrl_config;
  logic [7:0]  rx_frame_base_pointer;
  logic [7:0]  start_delimiter_config;
  logic [7:0]  pkt_config;
  logic [7:0]  delay_base;
  logic [7:0]  delay_ext;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [7:0]  buf_addr;
  logic [7:0]  rx_buf [256];
  logic [7:0]  buf_rdata;

  rxpm_pkg::rxpm_state_t state;
  rxpm_pkg::rxpm_state_t next_state;

  logic [10:0] delay_us;
  logic [6:0]  us_presc;
  logic [2:0]  pre_cnt;
  logic [3:0]  prev_sym;
  logic [3:0]  low_nib;
  logic        nib_hi;
  logic [7:0]  byte_idx;
  logic [6:0]  frame_len;
  logic [15:0] crc;
  logic [3:0]  ser_shift;
  logic [2:0]  ser_left;
  logic [1:0]  ser_tmr;

  // Bus decode
  wire [11:0] idx      = wb_adr_i[13:2];
  wire        access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr       = access & wb_we_i & wb_sel_i[0];
  wire        hit_bcfg = idx == rxpm_pkg::IDX_BUFFER_CONFIG;
  wire        hit_rcfg = idx == rxpm_pkg::IDX_RADIO_CTRL;
  wire        hit_base = idx == rxpm_pkg::IDX_RX_BASE_PTR;
  wire        hit_sfd  = idx == rxpm_pkg::IDX_START_DELIM;
  wire        hit_pcfg = idx == rxpm_pkg::IDX_PKT_CONFIG;
  wire        hit_dlyb = idx == rxpm_pkg::IDX_DELAY_BASE;
  wire        hit_dlye = idx == rxpm_pkg::IDX_DELAY_EXT;
  wire        hit_ists = idx == rxpm_pkg::IDX_IRQ_STATUS;
  wire        hit_imsk = idx == rxpm_pkg::IDX_IRQ_MASK;
  wire        hit_cmd  = idx == rxpm_pkg::IDX_COMMAND;
  wire        hit_rst  = idx == rxpm_pkg::IDX_RX_STATE;
  wire        hit_badr = idx == rxpm_pkg::IDX_BUF_ADDR;
  wire        hit_bdat = idx == rxpm_pkg::IDX_BUF_DATA;

  // Unmapped addresses read zero; every access is acknowledged
  wire [7:0] rd_byte = ({8{hit_bcfg}} & buffer_config)
                     | ({8{hit_rcfg}} & radio_ctrl_config)
                     | ({8{hit_base}} & rx_frame_base_pointer)
                     | ({8{hit_sfd}}  & start_delimiter_config)
                     | ({8{hit_pcfg}} & pkt_config)
                     | ({8{hit_dlyb}} & delay_base)
                     | ({8{hit_dlye}} & delay_ext)
                     | ({8{hit_ists}} & {5'h00, irq_status})
                     | ({8{hit_imsk}} & {5'h00, irq_mask})
                     | ({8{hit_rst}}  & {2'h0, state})
                     | ({8{hit_badr}} & buf_addr)
                     | ({8{hit_bdat}} & buf_rdata);

  // Commands are one-cycle pulses; they never store
  wire cmd_rx      = wr & hit_cmd & wb_dat_i[rxpm_pkg::CMD_RX_BIT];
  wire cmd_standby = wr & hit_cmd & wb_dat_i[rxpm_pkg::CMD_STANDBY_BIT];

  // Configuration decode
  wire [1:0] post_mode   = buffer_config[rxpm_pkg::POST_MODE_MSB:rxpm_pkg::POST_MODE_LSB];
  wire       serial_mode = radio_ctrl_config == rxpm_pkg::MODE_SERIAL;
  wire       packet_mode = radio_ctrl_config == rxpm_pkg::MODE_PACKET;
  wire       fcs_bypass  = pkt_config[rxpm_pkg::FCS_BYPASS_BIT];
  wire [3:0] sfd_lo      = start_delimiter_config[3:0];
  wire [3:0] sfd_hi      = start_delimiter_config[7:4];

  // Turn-on delay in microseconds; eleven bits so the largest base plus extension fits
  wire [10:0] delay_total = {3'h0, delay_base} + {1'b0, delay_ext, 2'h0};
  wire       us_tick     = us_presc == 7'(rxpm_pkg::CYC_PER_US - 1);
  wire       delay_done  = delay_us == 11'h000;

  // Symbol qualification
  wire in_pre    = state == rxpm_pkg::RXPM_PREAMB;
  wire in_sfd    = state == rxpm_pkg::RXPM_SFD;
  wire in_data   = state == rxpm_pkg::RXPM_DATA;
  wire pre_sym   = sym_data == rxpm_pkg::PREAMBLE_SYM;
  wire pre_done  = in_pre & sym_valid & pre_sym
                 & (pre_cnt == 3'(rxpm_pkg::PRE_QUAL_SYMS - 1));
  wire sfd_found = in_sfd & sym_valid & (prev_sym == sfd_lo)
                 & (sym_data == sfd_hi);
  wire sfd_lost  = in_sfd & sym_valid & ~sfd_found & ~pre_sym
                 & (sym_data != sfd_lo);

  // Byte assembly, low nibble first
  wire       byte_done = in_data & sym_valid & nib_hi;
  wire [7:0] rx_byte   = {sym_data, low_nib};
  wire       is_phr    = byte_idx == 8'h00;
  wire [7:0] len8      = {1'b0, frame_len};
  wire [7:0] eff_len   = is_phr ? {1'b0, rx_byte[6:0]} : len8;
  wire       last_byte = byte_done & (byte_idx == eff_len);
  wire [15:0] crc_next = rxpm_crc_byte(crc, rx_byte);
  // Residue zero over payload plus FCS means the check matches
  wire       crc_good  = crc_next == 16'h0000;
  wire       frame_ok  = fcs_bypass | (~is_phr & crc_good);
  wire       pkt_end   = last_byte & packet_mode;
  wire       frame_evt = pkt_end & frame_ok;
  wire       fcs_evt   = pkt_end & ~frame_ok;

  // Buffer write port; serial mode never touches the buffer
  wire       fcs_slot1 = ~fcs_bypass & ~is_phr & (byte_idx == len8 - 8'h01);
  wire       fcs_slot2 = ~fcs_bypass & ~is_phr & (byte_idx == len8);
  wire       buf_we    = byte_done & packet_mode;
  wire [7:0] buf_wa    = rx_frame_base_pointer + byte_idx;
  wire [7:0] buf_wd    = fcs_slot2 ? sqi_value
                       : fcs_slot1 ? rssi_value : rx_byte;

  // Interrupt status: a new event wins over a clear in the same cycle
  wire [2:0] irq_set   = {fcs_evt, frame_evt, sfd_found};
  wire [2:0] irq_clr   = (wr & hit_ists) ? wb_dat_i[2:0] : 3'h0;
  wire [2:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

  // Serial port pacing
  wire ser_load  = in_data & sym_valid & serial_mode;
  wire ser_phase = ser_tmr == 2'(rxpm_pkg::SERIAL_SYMBOL_PORT_HALF_CYC - 1);

  // Receive sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      rxpm_pkg::RXPM_STANDBY: begin
        next_state = rxpm_pkg::RXPM_STANDBY;
      end
      rxpm_pkg::RXPM_TURNON: begin
        if (delay_done) begin
          next_state = rxpm_pkg::RXPM_PREAMB;
        end
      end
      rxpm_pkg::RXPM_PREAMB: begin
        if (pre_done) begin
          next_state = rxpm_pkg::RXPM_SFD;
        end
      end
      rxpm_pkg::RXPM_SFD: begin
        if (sfd_found) begin
          next_state = rxpm_pkg::RXPM_DATA;
        end else if (sfd_lost) begin
          next_state = rxpm_pkg::RXPM_PREAMB;
        end
      end
      rxpm_pkg::RXPM_DATA: begin
        if (last_byte & serial_mode) begin
          next_state = rxpm_pkg::RXPM_PREAMB;
        end else if (fcs_evt) begin
          next_state = rxpm_pkg::RXPM_PREAMB;
        end else if (frame_evt) begin
          unique case (post_mode)
            rxpm_pkg::POST_STANDBY: next_state = rxpm_pkg::RXPM_STANDBY;
            rxpm_pkg::POST_STAY:    next_state = rxpm_pkg::RXPM_TURNON;
            default:                next_state = rxpm_pkg::RXPM_HOLD;
          endcase
        end else if (last_byte) begin
          next_state = rxpm_pkg::RXPM_PREAMB;
        end
      end
      rxpm_pkg::RXPM_HOLD: begin
        next_state = rxpm_pkg::RXPM_HOLD;
      end
      default: begin
        next_state = rxpm_pkg::RXPM_STANDBY;
      end
    endcase
    // Host commands override every state
    if (cmd_standby) begin
      next_state = rxpm_pkg::RXPM_STANDBY;
    end else if (cmd_rx) begin
      next_state = rxpm_pkg::RXPM_TURNON;
    end
  end

  // State register and receive status pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state             <= rxpm_pkg::RXPM_STANDBY;
      phy_standby_state <= 1'b1;
      rx_enabled        <= 1'b0;
    end else begin
      state             <= next_state;
      phy_standby_state <= next_state == rxpm_pkg::RXPM_STANDBY;
      rx_enabled        <= ~next_state[0];
    end
  end

  // Turn-on delay; reloaded on every entry so each receive re-arms fully
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      delay_us <= 11'h000;
      us_presc <= 7'h00;
    end else if (next_state == rxpm_pkg::RXPM_TURNON
                 && (state != rxpm_pkg::RXPM_TURNON || cmd_rx)) begin
      delay_us <= delay_total;
      us_presc <= 7'h00;
    end else if (us_tick) begin
      us_presc <= 7'h00;
      delay_us <= delay_done ? delay_us : delay_us - 11'h001;
    end else begin
      us_presc <= us_presc + 7'h01;
    end
  end

  // Preamble counter and previous symbol for delimiter match
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt  <= 3'h0;
      prev_sym <= 4'h0;
    end else if (!in_pre) begin
      pre_cnt  <= 3'h0;
      prev_sym <= sym_valid ? sym_data : prev_sym;
    end else if (sym_valid) begin
      pre_cnt  <= pre_sym ? pre_cnt + 3'h1 : 3'h0;
      prev_sym <= sym_data;
    end
  end

  // Frame assembly: length byte, byte index and running CRC
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nib_hi    <= 1'b0;
      low_nib   <= 4'h0;
      byte_idx  <= 8'h00;
      frame_len <= 7'h00;
      crc       <= 16'h0000;
    end else if (sfd_found) begin
      nib_hi    <= 1'b0;
      byte_idx  <= 8'h00;
      crc       <= 16'h0000;
    end else if (in_data && sym_valid) begin
      nib_hi  <= ~nib_hi;
      low_nib <= nib_hi ? low_nib : sym_data;
      if (nib_hi) begin
        byte_idx  <= byte_idx + 8'h01;
        frame_len <= is_phr ? rx_byte[6:0] : frame_len;
        crc       <= is_phr ? crc : crc_next;
      end
    end
  end

  // Frame storage and host read port
  always_ff @(posedge clk) begin
    if (buf_we) begin
      rx_buf[buf_wa] <= buf_wd;
    end
  end

  // Registered read of the buffer at the host pointer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_rdata <= 8'h00;
    end else begin
      buf_rdata <= rx_buf[buf_addr];
    end
  end

  // Serial symbol port: four clock pulses per symbol, LSB first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_shift        <= 4'h0;
      ser_left         <= 3'h0;
      ser_tmr          <= 2'h0;
      symbol_clock_out <= 1'b0;
      symbol_data_out  <= 1'b0;
    end else if (ser_load) begin
      ser_shift        <= sym_data;
      ser_left         <= 3'h4;
      ser_tmr          <= 2'h0;
      symbol_clock_out <= 1'b0;
      symbol_data_out  <= sym_data[0];
    end else if (ser_left != 3'h0) begin
      ser_tmr <= ser_phase ? 2'h0 : ser_tmr + 2'h1;
      if (ser_phase && !symbol_clock_out) begin
        symbol_clock_out <= 1'b1;
      end else if (ser_phase) begin
        symbol_clock_out <= 1'b0;
        ser_shift        <= ser_shift >> 1;
        symbol_data_out  <= ser_shift[1];
        ser_left         <= ser_left - 3'h1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_config          <= rxpm_pkg::RST_BUFFER_CONFIG;
      radio_ctrl_config      <= rxpm_pkg::RST_RADIO_CTRL;
      rx_frame_base_pointer  <= rxpm_pkg::RST_RX_BASE_PTR;
      start_delimiter_config <= rxpm_pkg::RST_START_DELIM;
      pkt_config             <= rxpm_pkg::RST_PKT_CONFIG;
      delay_base             <= rxpm_pkg::RST_DELAY_BASE;
      delay_ext              <= rxpm_pkg::RST_DELAY_EXT;
      irq_mask               <= rxpm_pkg::RST_IRQ;
      buf_addr               <= 8'h00;
    end else if (wr) begin
      if (hit_bcfg) buffer_config          <= wb_dat_i[7:0];
      if (hit_rcfg) radio_ctrl_config      <= wb_dat_i[7:0];
      if (hit_base) rx_frame_base_pointer  <= wb_dat_i[7:0];
      if (hit_sfd)  start_delimiter_config <= wb_dat_i[7:0];
      if (hit_pcfg) pkt_config             <= wb_dat_i[7:0];
      if (hit_dlyb) delay_base             <= wb_dat_i[7:0];
      if (hit_dlye) delay_ext              <= wb_dat_i[7:0];
      if (hit_imsk) irq_mask               <= wb_dat_i[2:0];
      if (hit_badr) buf_addr               <= wb_dat_i[7:0];
    end
  end

  // Interrupt status and level output, both straight from flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= rxpm_pkg::RST_IRQ;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // Bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

endmodule

// ---- design/rxpm_pkg.sv ----
package rxpm_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS   = 10;
  localparam int NS_PER_US       = 1000;
  localparam int CYC_PER_US      = NS_PER_US / CLK_PERIOD_NS;
  localparam int BASE_STEP_US    = 1;
  localparam int EXT_STEP_US     = 4;
  localparam int SERIAL_SYMBOL_PORT_HALF_CYC  = 2;
  localparam int PRE_QUAL_SYMS   = 4;

  // Register indices; the byte address is four times the index
  localparam logic [11:0] IDX_BUFFER_CONFIG   = 12'h107;
  localparam logic [11:0] IDX_RADIO_CTRL      = 12'h13E;
  localparam logic [11:0] IDX_RX_BASE_PTR     = 12'h315;
  localparam logic [11:0] IDX_START_DELIM     = 12'h3F4;
  localparam logic [11:0] IDX_PKT_CONFIG      = 12'h400;
  localparam logic [11:0] IDX_DELAY_BASE      = 12'h401;
  localparam logic [11:0] IDX_DELAY_EXT       = 12'h402;
  localparam logic [11:0] IDX_IRQ_STATUS      = 12'h403;
  localparam logic [11:0] IDX_IRQ_MASK        = 12'h404;
  localparam logic [11:0] IDX_COMMAND         = 12'h405;
  localparam logic [11:0] IDX_RX_STATE        = 12'h406;
  localparam logic [11:0] IDX_BUF_ADDR        = 12'h407;
  localparam logic [11:0] IDX_BUF_DATA        = 12'h408;

  // Reset values
  localparam logic [7:0] RST_BUFFER_CONFIG = 8'h00;
  localparam logic [7:0] RST_RADIO_CTRL    = 8'h00;
  localparam logic [7:0] RST_RX_BASE_PTR   = 8'h00;
  localparam logic [7:0] RST_START_DELIM   = 8'hA7;
  localparam logic [7:0] RST_PKT_CONFIG    = 8'h00;
  localparam logic [7:0] RST_DELAY_BASE    = 8'h00;
  localparam logic [7:0] RST_DELAY_EXT     = 8'h00;
  localparam logic [2:0] RST_IRQ           = 3'h0;

  // Field positions
  localparam int POST_MODE_MSB   = 1;
  localparam int POST_MODE_LSB   = 0;
  localparam int FCS_BYPASS_BIT  = 0;
  localparam int CMD_RX_BIT      = 0;
  localparam int CMD_STANDBY_BIT = 1;
  localparam int IRQ_SFD         = 0;
  localparam int IRQ_FRAME       = 1;
  localparam int IRQ_FCS_ERR     = 2;

  // Mode encodings
  localparam logic [1:0] POST_STANDBY = 2'h0;
  localparam logic [1:0] POST_STAY    = 2'h1;
  localparam logic [1:0] POST_HOLD    = 2'h2;
  localparam logic [7:0] MODE_PACKET  = 8'h00;
  localparam logic [7:0] MODE_SERIAL  = 8'h02;
  localparam logic [3:0] PREAMBLE_SYM = 4'h0;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;

  typedef enum logic [5:0] {
    RXPM_STANDBY = 6'b000001,
    RXPM_TURNON  = 6'b000010,
    RXPM_PREAMB  = 6'b000100,
    RXPM_SFD     = 6'b001000,
    RXPM_DATA    = 6'b010000,
    RXPM_HOLD    = 6'b100000
  } rxpm_state_t;

endpackage

// ---- bench/rxpm_top_chk.sv ----
`timescale 1ns/1ps
module rxpm_top_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [13:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_ack_o,
  input wire logic        sym_valid,
  input wire logic [3:0]  sym_data,
  input wire logic [7:0]  rssi_value,
  input wire logic [7:0]  sqi_value,
  input wire logic        symbol_clock_out,
  input wire logic        symbol_data_out,
  input wire logic        phy_standby_state,
  input wire logic        rx_enabled,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Request taken this edge, and the command register among them
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire cmd = req && wb_we_i && wb_sel_i[0] && wb_adr_i[13:2] == rxpm_pkg::IDX_COMMAND;
  // One serial clock pulse: two cycles high, then low
  sequence s_pulse;
    symbol_clock_out ##1 !symbol_clock_out;
  endsequence
  property p_ack_next;
    req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h00000000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_state_excl;
    phy_standby_state == !rx_enabled;
  endproperty
  a_state_excl: assert property (p_state_excl) else $error("standby and receive disagree");
  property p_sclk_high;
    $rose(symbol_clock_out) |=> s_pulse;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("serial clock high time wrong");
  property p_sclk_low;
    $fell(symbol_clock_out) |=> !symbol_clock_out;
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("serial clock low time wrong");
  property p_sdata_hold;
    symbol_clock_out |-> $stable(symbol_data_out);
  endproperty
  a_sdata_hold: assert property (p_sdata_hold) else $error("serial data moved on clock");
  property p_cmd_rx;
    cmd && wb_dat_i[1:0] == 2'b01 |-> ##[1:2] rx_enabled;
  endproperty
  a_cmd_rx: assert property (p_cmd_rx) else $error("receive command ignored");
  property p_cmd_stby;
    cmd && wb_dat_i[1] |-> ##[1:2] phy_standby_state;
  endproperty
  a_cmd_stby: assert property (p_cmd_stby) else $error("standby command ignored");
endmodule
bind rxpm_top rxpm_top_chk i_chk (
  .clk(clk), .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
  .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .sym_valid(sym_valid), .sym_data(sym_data),
  .rssi_value(rssi_value), .sqi_value(sqi_value), .symbol_clock_out(symbol_clock_out),
  .symbol_data_out(symbol_data_out), .phy_standby_state(phy_standby_state),
  .rx_enabled(rx_enabled), .irq(irq)
);

// ---- bench/rxpm_sym_src.sv ----
`timescale 1ns/1ps
module rxpm_sym_src (
  input  wire logic       clk,
  output logic            sym_valid,
  output logic [3:0]      sym_data,
  output logic [7:0]      rssi_value,
  output logic [7:0]      sqi_value
);
  int gap = 1;
  initial begin
    sym_valid = 1'b0;
    sym_data = 4'h5;
    rssi_value = 8'hC3;
    sqi_value = 8'h5A;
  end
  // One symbol; afterwards the line shows the inverse so stale data never looks valid
  task automatic nib(input logic [3:0] n);
    @(posedge clk);
    sym_valid <= 1'b1;
    sym_data <= n;
    @(posedge clk);
    sym_valid <= 1'b0;
    sym_data <= ~n;
    repeat (gap - 1) @(posedge clk);
  endtask
  task automatic octet(input logic [7:0] b);
    nib(b[3:0]);
    nib(b[7:4]);
  endtask
  // Preamble of zero symbols, then the delimiter, low nibble first
  task automatic head(input logic [7:0] sfd);
    repeat (4) nib(4'h0);
    octet(sfd);
  endtask
endmodule

// ---- bench/rxpm_top_bench.sv ----
`timescale 1ns/1ps
module rxpm_top_bench;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [31:0] dat = 32'h00000000;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic        stb = 1'b0;
  logic        cyc = 1'b0;
  logic [31:0] dout;
  logic        ack, sym_valid, sclk, sdat, stby, rxen, irq;
  logic [3:0]  sym_data;
  logic [7:0]  rssi, sqi, q;
  logic [15:0] fcs;
  logic [15:0] sh = 16'h0000;
  int          pulses = 0;
  int          cycles = 0;
  int          bad_count = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;

  rxpm_top i_dut (
    .clk(clk), .reset_n(reset_n), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dout),
    .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack),
    .sym_valid(sym_valid), .sym_data(sym_data), .rssi_value(rssi), .sqi_value(sqi),
    .symbol_clock_out(sclk), .symbol_data_out(sdat), .phy_standby_state(stby),
    .rx_enabled(rxen), .irq(irq)
  );
  rxpm_sym_src i_src (
    .clk(clk), .sym_valid(sym_valid), .sym_data(sym_data), .rssi_value(rssi),
    .sqi_value(sqi)
  );

  // Serial bits arrive least significant first, so the last byte lands on top
  always @(posedge sclk) begin
    pulses++;
    sh <= {sdat, sh[15:1]};
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is seen high at a rising edge
  task automatic wb(input logic [11:0] idx, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dout[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) chk(8'h00, 8'hFF);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    wb(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    chk(q, exp);
  endtask
  task automatic bufchk(input logic [7:0] a, input logic [7:0] exp);
    wr(rxpm_pkg::IDX_BUF_ADDR, a);
    rd(rxpm_pkg::IDX_BUF_DATA, exp);
  endtask

  function automatic logic [15:0] crc(input logic [7:0] b, input logic [15:0] c);
    for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction

  // Length four: two payload bytes and the check bytes, low byte first
  task automatic frame(input logic [7:0] sfd, input logic [7:0] a, input logic bad);
    fcs = crc(8'h3C, crc(a, 16'h0000));
    fcs[0] = fcs[0] ^ bad;
    i_src.head(sfd);
    i_src.octet(8'h04);
    i_src.octet(a);
    i_src.octet(8'h3C);
    i_src.octet(fcs[7:0]);
    i_src.octet(fcs[15:8]);
    repeat (6) @(posedge clk);
  endtask

  task automatic final_report();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run is about a thousand cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(rxpm_pkg::IDX_BUFFER_CONFIG, 8'h00);
    rd(rxpm_pkg::IDX_RADIO_CTRL, 8'h00);
    rd(rxpm_pkg::IDX_RX_BASE_PTR, 8'h00);
    rd(rxpm_pkg::IDX_START_DELIM, 8'hA7);
    rd(12'h7FF, 8'h00);
    rd(rxpm_pkg::IDX_RX_STATE, 8'h01);
    // Five microseconds of turn-on: one base step and one extension step
    wr(rxpm_pkg::IDX_DELAY_BASE, 8'h01);
    wr(rxpm_pkg::IDX_DELAY_EXT, 8'h01);
    wr(rxpm_pkg::IDX_IRQ_MASK, 8'h07);
    wr(rxpm_pkg::IDX_RX_BASE_PTR, 8'h10);
    wr(rxpm_pkg::IDX_START_DELIM, 8'h5C);
    wr(rxpm_pkg::IDX_COMMAND, 8'h01);
    repeat (470) @(posedge clk);
    rd(rxpm_pkg::IDX_RX_STATE, 8'h02);
    repeat (40) @(posedge clk);
    rd(rxpm_pkg::IDX_RX_STATE, 8'h04);
    frame(8'h5C, 8'h96, 1'b0);
    rd(rxpm_pkg::IDX_IRQ_STATUS, 8'h03);
    chk({7'h00, stby}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    bufchk(8'h10, 8'h04);
    bufchk(8'h11, 8'h96);
    bufchk(8'h13, 8'hC3);
    bufchk(8'h14, 8'h5A);
    wr(rxpm_pkg::IDX_IRQ_STATUS, 8'h07);
    chk({7'h00, irq}, 8'h00);
    // Stay in receive, then a corrupted frame must not count as received
    wr(rxpm_pkg::IDX_DELAY_BASE, 8'h00);
    wr(rxpm_pkg::IDX_DELAY_EXT, 8'h00);
    wr(rxpm_pkg::IDX_BUFFER_CONFIG, 8'h01);
    wr(rxpm_pkg::IDX_COMMAND, 8'h01);
    frame(8'h5C, 8'h21, 1'b0);
    rd(rxpm_pkg::IDX_IRQ_STATUS, 8'h03);
    chk({7'h00, rxen}, 8'h01);
    wr(rxpm_pkg::IDX_IRQ_STATUS, 8'h07);
    frame(8'h5C, 8'h44, 1'b1);
    rd(rxpm_pkg::IDX_IRQ_STATUS, 8'h05);
    wr(rxpm_pkg::IDX_IRQ_MASK, 8'h02);
    // The level output follows a mask write one cycle after the write lands
    @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    wr(rxpm_pkg::IDX_IRQ_STATUS, 8'h07);
    // Check bytes kept when checking is off; hold mode then freezes the buffer
    wr(rxpm_pkg::IDX_PKT_CONFIG, 8'h01);
    wr(rxpm_pkg::IDX_BUFFER_CONFIG, 8'h02);
    wr(rxpm_pkg::IDX_RX_BASE_PTR, 8'h20);
    wr(rxpm_pkg::IDX_COMMAND, 8'h01);
    frame(8'h5C, 8'h6B, 1'b1);
    chk({7'h00, irq}, 8'h01);
    rd(rxpm_pkg::IDX_RX_STATE, 8'h20);
    // Check bytes as sent, already corrupted; read before the next frame reuses fcs
    bufchk(8'h23, fcs[7:0]);
    bufchk(8'h24, fcs[15:8]);
    frame(8'h5C, 8'h99, 1'b0);
    bufchk(8'h21, 8'h6B);
    // Serial port: length byte and one data byte shifted out, receive held afterwards
    wr(rxpm_pkg::IDX_COMMAND, 8'h02);
    wr(rxpm_pkg::IDX_IRQ_STATUS, 8'h07);
    wr(rxpm_pkg::IDX_RADIO_CTRL, 8'h02);
    wr(rxpm_pkg::IDX_COMMAND, 8'h01);
    i_src.gap = 19;
    i_src.head(8'h5C);
    i_src.octet(8'h01);
    i_src.octet(8'hB6);
    repeat (30) @(posedge clk);
    chk(sh[15:8], 8'hB6);
    chk({6'h00, pulses[1:0]}, 8'h00);
    chk({7'h00, rxen}, 8'h01);
    rd(rxpm_pkg::IDX_IRQ_STATUS, 8'h01);
    final_report();
  end
endmodule
